// file: hw/cpm_map.svh
// Constant map for the card power mode controller
`ifndef CPM_MAP_SVH
`define CPM_MAP_SVH

// ==========================================================
// Timing
`define CPM_CLK_PERIOD_NS 10
`define CPM_IDLE_TIME_US 4000
`define CPM_IDLE_CYCLES ((`CPM_IDLE_TIME_US * 1000) / `CPM_CLK_PERIOD_NS)
`define CPM_WAIT_MAX_NS 350
`define CPM_WAIT_MAX_CYCLES (`CPM_WAIT_MAX_NS / `CPM_CLK_PERIOD_NS)

// ==========================================================
// Cycle-time mode codes
`define CPM_CYC_250NS 2'h0
`define CPM_CYC_120NS 2'h1
`define CPM_CYC_100NS 2'h2
`define CPM_CYC_80NS  2'h3

`endif

// file: hw/cpm_pkg.sv
// Types for the card power mode controller
package cpm_pkg;

    typedef enum logic [1:0]
    {
        CPM_INIT,
        CPM_STANDBY,
        CPM_ACTIVE,
        CPM_SLEEP
    } cpm_state_e;

endpackage : cpm_pkg

// file: hw/cpm_power_ctrl.sv
// Power mode state machine, idle timer, clock gate and wait-stall control
`timescale 1ns/10ps
`include "cpm_map.svh"

module cpm_power_ctrl
    import cpm_pkg::*;
#(
    parameter int unsigned IDLE_W       = 24,
    parameter int unsigned IDLE_DEFAULT = `CPM_IDLE_CYCLES,
    parameter int unsigned WAIT_W       = 6,
    parameter int unsigned WAIT_MAX     = `CPM_WAIT_MAX_CYCLES
)
(
    // Clock and reset
    input  wire logic                ref_clk,
    input  wire logic                rst,
    // Host events, one-cycle pulses
    input  wire logic                cmd_in,
    input  wire logic                soft_rst,
    input  wire logic                sleep_cmd,
    // Asynchronous wake, level, seen while the clock is gated
    input  wire logic                wake_async,
    // Firmware controls
    input  wire logic                init_done,
    input  wire logic                idle_load,
    input  wire logic [IDLE_W-1:0]   idle_limit,
    // Strobe timing
    input  wire logic [1:0]          cycle_mode,
    input  wire logic                strobe_act,
    input  wire logic                data_ready,
    // Status
    output logic [1:0]               power_state,
    output logic                     clk_run,
    output logic                     sleep_req,
    output logic                     wait_n
);

    // ==========================================================
    // Registers
    cpm_state_e         state_reg;
    cpm_state_e         state_next;
    logic [IDLE_W-1:0]  limit_reg;
    logic [IDLE_W-1:0]  idle_cnt_reg;
    logic [IDLE_W-1:0]  idle_cnt_next;
    logic               wait_n_reg;
    logic [WAIT_W-1:0]  wait_cnt_reg;

    // ==========================================================
    // Helpers
    // Shared by the state machine, the timer and sleep_req
    function automatic logic idle_reached
    (
        input logic [IDLE_W-1:0] count,
        input logic [IDLE_W-1:0] limit
    );
        return (count >= limit);
    endfunction : idle_reached

    // Saturates so a misloaded limit can never wrap the timer
    function automatic logic [IDLE_W-1:0] idle_step
    (
        input logic [IDLE_W-1:0] count
    );
        logic [IDLE_W-1:0] stepped;
        stepped = count + 1'b1;
        return (&count) ? count : stepped;
    endfunction : idle_step

    // ==========================================================
    // Decode
    // Commands and soft resets are the only activity that holds off sleep
    wire logic host_event  = cmd_in | soft_rst;
    wire logic idle_expire = idle_reached(idle_cnt_reg, limit_reg);
    wire logic wake_hit    = host_event | wake_async;
    wire logic in_active   = (state_reg == CPM_ACTIVE);
    wire logic in_sleep    = (state_reg == CPM_SLEEP);
    wire logic fast_mode   = (cycle_mode == `CPM_CYC_80NS);
    wire logic wait_cap    = (wait_cnt_reg >= WAIT_W'(WAIT_MAX - 1));
    wire logic wait_count  = strobe_act & ~wait_n_reg;
    wire logic stall_want  = strobe_act & ~data_ready & ~fast_mode & ~wait_cap;

    // ==========================================================
    // State machine
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            CPM_INIT:
            begin
                if (init_done)
                    state_next = CPM_STANDBY;
            end
            CPM_STANDBY:
            begin
                if (host_event)
                    state_next = CPM_ACTIVE;
            end
            CPM_ACTIVE:
            begin
                // Sleep command wins over a command in the same cycle
                if (sleep_cmd)
                    state_next = CPM_SLEEP;
                else if (!host_event && idle_expire)
                    state_next = CPM_SLEEP;
            end
            CPM_SLEEP:
            begin
                // Wake arrives as an async level since the clock is gated
                if (wake_hit)
                    state_next = CPM_ACTIVE;
            end
            default:
                state_next = CPM_INIT;
        endcase
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            state_reg <= CPM_INIT;
        else
            state_reg <= state_next;
    end

    // ==========================================================
    // Idle timer
    // Cleared on entry to active so a stale count never cuts a session short
    always_comb
    begin
        idle_cnt_next = idle_cnt_reg;
        case (state_reg)
            CPM_STANDBY:
            begin
                if (host_event)
                    idle_cnt_next = '0;
            end
            CPM_ACTIVE:
            begin
                if (host_event)
                    idle_cnt_next = '0;
                else if (!sleep_cmd && !idle_expire)
                    idle_cnt_next = idle_step(idle_cnt_reg);
            end
            CPM_SLEEP:
            begin
                if (wake_hit)
                    idle_cnt_next = '0;
            end
            default:
                idle_cnt_next = idle_cnt_reg;
        endcase
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            idle_cnt_reg <= '0;
        else
            idle_cnt_reg <= idle_cnt_next;
    end

    // ==========================================================
    // Firmware idle limit
    // Loads at any time; a new limit applies to the count already running
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            limit_reg <= IDLE_W'(IDLE_DEFAULT);
        else if (idle_load)
            limit_reg <= idle_limit;
    end

    // ==========================================================
    // Wait-stall, bounded to the maximum wait width
    // Counter holds once capped until the strobe ends, so one strobe stalls for at most WAIT_MAX cycles in total
    wire logic              wait_clear = ~strobe_act;
    logic [WAIT_W-1:0]      wait_cnt_next;
    assign wait_cnt_next = wait_count ? WAIT_W'(wait_cnt_reg + 1'b1)
                         : (wait_clear ? '0 : wait_cnt_reg);

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            wait_n_reg <= 1'b1;
        else
            wait_n_reg <= ~stall_want;
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            wait_cnt_reg <= '0;
        else
            wait_cnt_reg <= wait_cnt_next;
    end

    // ==========================================================
    // Clock gate
    // Combinational so a wake restarts the clock before the next edge;
    // whatever gates the clock must accept this enable changing mid-cycle
    assign clk_run     = ~in_sleep | wake_hit;

    // ==========================================================
    // Outputs
    // Codes: 0 init, 1 standby, 2 active, 3 sleep
    assign power_state = state_reg;
    assign sleep_req   = in_active & idle_expire & ~host_event;
    assign wait_n      = wait_n_reg;

endmodule : cpm_power_ctrl

// file: tb/cpm_chk_checker.sv
// Port assertions for the power mode controller
`timescale 1ns/10ps
module cpm_chk
(
    // Inputs
    input wire logic       ref_clk,
    input wire logic       rst,
    input wire logic       cmd_in,
    input wire logic       soft_rst,
    input wire logic       sleep_cmd,
    input wire logic       wake_async,
    input wire logic       init_done,
    input wire logic [1:0] cycle_mode,
    // Outputs
    input wire logic [1:0] power_state,
    input wire logic       clk_run,
    input wire logic       sleep_req,
    input wire logic       wait_n
);
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (rst);
    wire       ev = cmd_in | soft_rst;
    // One-hot view: init, standby, active, sleep
    wire [3:0] st = 4'h1 << power_state;
    a_init_standby: assert property (st[0] && init_done |=> st[1])
        else $error("no standby");
    a_standby_hold: assert property (st[1] && !ev |=> st[1])
        else $error("left standby");
    a_event_active: assert property ((st[1] || st[2]) && ev && !sleep_cmd |=> st[2])
        else $error("not active");
    a_sleep_cmd: assert property (st[2] && sleep_cmd |=> st[3])
        else $error("no sleep");
    a_idle_sleep: assert property (sleep_req && !ev |-> st[2] ##1 st[3])
        else $error("no idle sleep");
    a_clock_gate: assert property (st[3] |-> clk_run == (wake_async || ev))
        else $error("clock gate");
    a_wake_up: assert property (st[3] && (wake_async || ev) |=> st[2])
        else $error("no wake");
    a_no_stall: assert property (cycle_mode == 2'h3 |=> wait_n)
        else $error("stall");
endmodule : cpm_chk

// file: tb/cpm_host.sv
// Host model issuing one-cycle events
`timescale 1ns/10ps
module cpm_host
(
    // Request
    input wire logic       ref_clk,
    input wire logic [1:0] ev_kind,
    // Events
    output logic           cmd_in = 1'b0,
    output logic           soft_rst = 1'b0,
    output logic           sleep_cmd = 1'b0
);
    always @(negedge ref_clk)
    begin
        cmd_in <= ev_kind == 2'h1;
        soft_rst <= ev_kind == 2'h2;
        sleep_cmd <= ev_kind == 2'h3;
    end
endmodule : cpm_host

// file: tb/test_card_power_mode_control.sv
// Testbench for the power mode controller
`timescale 1ns/10ps
module test_card_power_mode_control;
    logic ref_clk = 1'b0, rst = 1'b1, wake_async = 1'b0, init_done = 1'b0, idle_load = 1'b0;
    logic strobe_act = 1'b0, data_ready = 1'b0, exp_w = 1'b1;
    logic [1:0] ev_kind = 2'h0, cycle_mode = 2'h0, power_state;
    logic [23:0] idle_limit = 24'h0;
    logic cmd_in, soft_rst, sleep_cmd, clk_run, sleep_req, wait_n;
    logic [31:0] lfsr = 32'hC95131EF;
    int n_errors = 0, tests_run = 0, k;
    initial forever #5 ref_clk = ~ref_clk;
    cpm_host host (.ref_clk, .ev_kind, .cmd_in, .soft_rst, .sleep_cmd);
    cpm_power_ctrl #(.IDLE_DEFAULT(20)) dut (.ref_clk, .rst, .cmd_in, .soft_rst,
        .sleep_cmd, .wake_async, .init_done, .idle_load, .idle_limit, .cycle_mode,
        .strobe_act, .data_ready, .power_state, .clk_run, .sleep_req, .wait_n);
    function automatic logic [31:0] step(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : step
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        n_errors += (got !== exp);
        if (got !== exp)
            $display("MISMATCH %0t %h %h", $time, got, exp);
    endtask : chk
    task automatic complete_run();
        $display("errors %0d checks %0d", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : complete_run
    task automatic send(input logic [1:0] kind);
        @(posedge ref_clk);
        ev_kind = kind;
        @(posedge ref_clk);
        ev_kind = 2'h0;
        @(negedge ref_clk);
    endtask : send
    // Bounded wait for sleep, then wake through the async path
    task automatic nap(input logic [7:0] exp);
        for (k = 0; k < 99 && power_state !== 2'h3; k++)
            @(negedge ref_clk);
        chk(8'(k), exp);
        chk(8'(clk_run), 8'h0);
        wake_async = 1'b1;
        #1 chk(8'(clk_run), 8'h1);
        @(negedge ref_clk);
        wake_async = 1'b0;
        chk(8'(power_state), 8'h2);
    endtask : nap
    initial
    begin
        repeat (20) @(negedge ref_clk);
        rst = 1'b0;
        send(2'h1);
        chk(8'(power_state), 8'h0);
        init_done = 1'b1;
        send(2'h3);
        chk(8'(power_state), 8'h1);
        send(2'h2);
        chk(8'(power_state), 8'h2);
        nap(8'h15);
        idle_limit = 24'h5;
        idle_load = 1'b1;
        @(negedge ref_clk);
        idle_load = 1'b0;
        send(2'h1);
        nap(8'h6);
        send(2'h3);
        chk(8'(power_state), 8'h3);
        wake_async = 1'b1;
        @(posedge ref_clk);
        ev_kind = 2'h1;
        @(negedge ref_clk);
        wake_async = 1'b0;
        chk(8'(power_state), 8'h2);
        // Host treats 350 ns as the longest stall it will honour
        cycle_mode = 2'h0;
        strobe_act = 1'b1;
        data_ready = 1'b0;
        k = 0;
        repeat (40)
        begin
            @(negedge ref_clk);
            k += !wait_n;
        end
        chk(8'(k), 8'h23);
        strobe_act = 1'b0;
        @(negedge ref_clk);
        exp_w = 1'b1;
        // ev_kind is left at 1, so cmd_in stays high and the card stays active while strobes run
        repeat (300)
        begin
            @(negedge ref_clk);
            chk(8'(wait_n), 8'(exp_w));
            lfsr = step(lfsr);
            {cycle_mode, strobe_act, data_ready} = lfsr[3:0];
            exp_w = !(strobe_act && !data_ready && cycle_mode != 2'h3);
        end
        complete_run();
    end
endmodule : test_card_power_mode_control
bind cpm_power_ctrl cpm_chk chk (.ref_clk, .rst, .cmd_in, .soft_rst, .sleep_cmd,
    .wake_async, .init_done, .cycle_mode, .power_state, .clk_run, .sleep_req, .wait_n);
